// *** design/serial_port_defs.vh ***
/*
  Constants of the second asynchronous serial port: register indices,
  field positions, reset values, rate divisors and filter lengths.
  Assumes it is included by bare name from the design files.
*/
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_CONTROL_A 12'hf98
`define IDX_STATUS 12'hf98
`define IDX_RX_HOLDING 12'hf9a
`define IDX_TX_HOLDING 12'hf9a
`define IDX_CONTROL_B 12'hf99
`define IDX_TIMER_PERIOD 12'hf9b

// ==========================================================
// Line control A fields
`define CA_TX_ENABLE 7
`define CA_RX_ENABLE 6
`define CA_STOP_LEN 5
`define CA_PARITY_SENSE 4
`define CA_PARITY_ON 3
`define CA_RATE_HI 2
`define CA_RATE_LO 0

// Line control B fields
`define CB_FILTER_HI 1
`define CB_FILTER_LO 0

// Status fields
`define ST_PARITY_FAULT 7
`define ST_FRAME_FAULT 6
`define ST_OVERFLOW_FAULT 5
`define ST_RX_FULL 4
`define ST_TX_DONE 3
`define ST_TX_EMPTY 2

// ==========================================================
// Reset values
`define CONTROL_A_RESET 8'h00
`define CONTROL_B_RESET 8'h00
`define TIMER_PERIOD_RESET 8'h01
`define HOLDING_RESET 8'h00

// ==========================================================
// Transfer clock divisors of fc
`define DIV_CODE0 9'h00d
`define DIV_CODE1 9'h01a
`define DIV_CODE2 9'h034
`define DIV_CODE3 9'h068
`define DIV_CODE4 9'h0d0
`define DIV_CODE5 9'h1a0
`define DIV_CODE7 9'h060
`define DIV_TIMER_ZERO 9'h100
`define RATE_CODE_TIMER 3'h6

// ==========================================================
// Sample ticks within one bit
`define RT_LAST 4'hf
`define RT_SAMPLE_A 4'h7
`define RT_SAMPLE_B 4'h8
`define RT_SAMPLE_C 4'h9

// Glitch filter lengths in fc cycles
`define FILTER_LEN_1 9'h060
`define FILTER_LEN_2 9'h0c0
`define FILTER_LEN_3 9'h180

`endif

// *** design/serial_rate_gen.v ***
/*
  Transfer clock generator: one-cycle sample tick at the selected
  division of the system clock, or at the timer period.
  Assumes the rate is only changed while both directions are idle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_defs.vh"

module serial_rate_gen (
  // Clock and reset
  input wire i_clock,
  input wire i_reset,
  // Settings
  input wire [2:0] i_rate_select,
  input wire [7:0] i_timer_period,
  // Tick
  output reg o_tick
);

  // ==========================================================
  // Divisor selection
  function [8:0] rate_divisor;
    input [2:0] code;
    input [7:0] period;
    begin
      case (code)
        3'h0: rate_divisor = `DIV_CODE0;
        3'h1: rate_divisor = `DIV_CODE1;
        3'h2: rate_divisor = `DIV_CODE2;
        3'h3: rate_divisor = `DIV_CODE3;
        3'h4: rate_divisor = `DIV_CODE4;
        3'h5: rate_divisor = `DIV_CODE5;
        `RATE_CODE_TIMER: begin
          if (period == 8'h00) begin
            rate_divisor = `DIV_TIMER_ZERO;
          end else begin
            rate_divisor = {1'b0, period};
          end
        end
        default: rate_divisor = `DIV_CODE7;
      endcase
    end
  endfunction

  // ==========================================================
  // Divider
  reg [8:0] count;
  wire [8:0] last = rate_divisor(i_rate_select, i_timer_period) - 9'h001;

  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      count <= 9'h000;
      o_tick <= 1'b0;
    end else begin
      if (count >= last) begin
        count <= 9'h000;
        o_tick <= 1'b1;
      end else begin
        count <= count + 9'h001;
        o_tick <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// *** design/async_serial_port_two.v ***
/*
  Second asynchronous serial port with an APB register slave,
  one holding register per direction and status flags.
  Assumes a synchronous APB master on i_clock and a serial partner
  at the same bit rate and format.
*/
// Our own choice: the APB slave port.
// Summary of operation
// - Start bit low, data, parity, high stops
// - Transmit one or two stop bits
// - Parity only when on; sense 0 odd
// - Rate codes divide fc by 13..416
// - Code 110 uses timer period divisor
// - Find low start, vote ticks 7,8,9
// - Glitch filter 96, 192, 384 cycles
// - Holding write clears empty, starts send
// - Send start sets empty, pulses tx irq
// - Output high when disabled or unwritten
// - Write without status read is ignored
// - Stale data not sent on enable
// - Load received data, set full, rx irq
// - Overrun discards new character
// - Disable waits for current character
// - Parity fault, cleared status then read
// - Rate and parity shared both ways
// - Reset status reads 0000 11 then 00
// - Frame fault on low stop sample
// - Overflow fault blocks reception till cleared
// - Full flag set on load, cleared by reads
// - Done flag set when sent and empty
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_defs.vh"

module async_serial_port_two (
  // Clock and reset
  input wire i_clock,
  input wire i_reset,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [15:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output reg o_pslverr,
  // Serial line
  input wire i_serial_in_pin,
  output reg o_serial_out_pin,
  // Events
  output reg o_tx_irq,
  output reg o_rx_irq
);

  localparam REGION_NONE = 3'h0;
  localparam REGION_LINE = 3'h1;
  localparam REGION_HOLD = 3'h2;
  localparam REGION_CTRL_B = 3'h3;
  localparam REGION_TIMER = 3'h4;

  // ==========================================================
  // Address decoding
  function [2:0] decode;
    input [15:0] addr;
    begin
      if (addr[1:0] != 2'h0 || addr[15:14] != 2'h0) begin
        decode = REGION_NONE;
      end else if (addr[13:2] == `IDX_CONTROL_A) begin
        decode = REGION_LINE;
      end else if (addr[13:2] == `IDX_TX_HOLDING) begin
        decode = REGION_HOLD;
      end else if (addr[13:2] == `IDX_CONTROL_B) begin
        decode = REGION_CTRL_B;
      end else if (addr[13:2] == `IDX_TIMER_PERIOD) begin
        decode = REGION_TIMER;
      end else begin
        decode = REGION_NONE;
      end
    end
  endfunction

  // ==========================================================
  // Register state
  reg [7:0] control_a;
  reg [7:0] control_b;
  reg [7:0] timer_period;
  reg [7:0] rx_holding;
  reg [7:0] tx_holding;
  reg parity_fault_flag;
  reg frame_fault_flag;
  reg overflow_fault_flag;
  reg rx_holding_full;
  reg tx_done_flag;
  reg tx_holding_empty;
  reg rx_armed;
  reg tx_armed;
  reg ack;

  wire tx_enable_bit = control_a[`CA_TX_ENABLE];
  wire rx_enable_bit = control_a[`CA_RX_ENABLE];
  wire stop_len_select = control_a[`CA_STOP_LEN];
  wire parity_sense = control_a[`CA_PARITY_SENSE];
  wire parity_on = control_a[`CA_PARITY_ON];
  wire [1:0] rx_glitch_filter = control_b[`CB_FILTER_HI:`CB_FILTER_LO];

  wire [7:0] status = {parity_fault_flag, frame_fault_flag,
    overflow_fault_flag, rx_holding_full, tx_done_flag,
    tx_holding_empty, 2'b00};

  // ==========================================================
  // APB access
  wire access = i_psel & i_penable;
  wire finish = access & ack;
  wire [2:0] region = decode(i_paddr);
  wire status_read = finish & ~i_pwrite & (region == REGION_LINE);
  wire rx_read = finish & ~i_pwrite & (region == REGION_HOLD);
  wire tx_write = finish & i_pwrite & (region == REGION_HOLD);
  wire tx_write_ok = tx_write & tx_armed;
  wire rx_clear = rx_read & rx_armed;

  assign o_pready = ack;

  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      ack <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      ack <= access & ~ack;
      if (access & ~ack) begin
        o_pslverr <= (region == REGION_NONE);
        if (i_pwrite) begin
          o_prdata <= 32'h0000_0000;
        end else if (region == REGION_LINE) begin
          o_prdata <= {24'h00_0000, status};
        end else if (region == REGION_HOLD) begin
          o_prdata <= {24'h00_0000, rx_holding};
        end else if (region == REGION_CTRL_B) begin
          o_prdata <= {24'h00_0000, control_b};
        end else if (region == REGION_TIMER) begin
          o_prdata <= {24'h00_0000, timer_period};
        end else begin
          o_prdata <= 32'h0000_0000;
        end
      end
    end
  end

  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      control_a <= `CONTROL_A_RESET;
      control_b <= `CONTROL_B_RESET;
      timer_period <= `TIMER_PERIOD_RESET;
      rx_armed <= 1'b0;
      tx_armed <= 1'b0;
    end else begin
      if (finish & i_pwrite & (region == REGION_LINE)) begin
        control_a <= i_pwdata[7:0];
      end
      if (finish & i_pwrite & (region == REGION_CTRL_B)) begin
        control_b <= i_pwdata[7:0];
      end
      if (finish & i_pwrite & (region == REGION_TIMER)) begin
        timer_period <= i_pwdata[7:0];
      end
      if (status_read) begin
        rx_armed <= 1'b1;
      end else if (rx_read) begin
        rx_armed <= 1'b0;
      end
      if (status_read) begin
        tx_armed <= 1'b1;
      end else if (tx_write) begin
        tx_armed <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Shared transfer clock
  wire rt_tick;

  serial_rate_gen rate_gen (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_rate_select(control_a[`CA_RATE_HI:`CA_RATE_LO]),
    .i_timer_period(timer_period),
    .o_tick(rt_tick)
  );

  // ==========================================================
  // Transmitter
  reg [3:0] tx_rt;
  reg tx_busy;
  reg tx_pending;
  reg tx_enable_prev;
  reg [11:0] tx_shift;
  reg [3:0] tx_left;
  wire tx_bit_tick = rt_tick & (tx_rt == `RT_LAST);
  wire tx_parity = ^tx_holding ^ ~parity_sense;
  wire tx_enable_rise = tx_enable_bit & ~tx_enable_prev;
  wire tx_start = ~tx_busy & tx_pending & tx_enable_bit & tx_bit_tick;

  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      tx_rt <= 4'h0;
      tx_busy <= 1'b0;
      tx_pending <= 1'b0;
      tx_enable_prev <= 1'b0;
      tx_shift <= 12'hfff;
      tx_left <= 4'h0;
      tx_holding <= `HOLDING_RESET;
      tx_holding_empty <= 1'b1;
      tx_done_flag <= 1'b1;
      o_serial_out_pin <= 1'b1;
      o_tx_irq <= 1'b0;
    end else begin
      tx_enable_prev <= tx_enable_bit;
      o_tx_irq <= 1'b0;
      if (rt_tick) begin
        tx_rt <= tx_rt + 4'h1;
      end
      if (tx_enable_rise & tx_pending) begin
        tx_pending <= 1'b0;
        tx_holding_empty <= 1'b1;
      end
      if (tx_write_ok) begin
        tx_holding <= i_pwdata[7:0];
        tx_pending <= 1'b1;
        tx_holding_empty <= 1'b0;
      end
      if (tx_start) begin
        tx_busy <= 1'b1;
        tx_pending <= tx_write_ok;
        tx_holding_empty <= ~tx_write_ok;
        tx_done_flag <= 1'b0;
        o_tx_irq <= 1'b1;
        o_serial_out_pin <= 1'b0;
        if (parity_on) begin
          tx_shift <= {3'b111, tx_parity, tx_holding};
          tx_left <= stop_len_select ? 4'hb : 4'ha;
        end else begin
          tx_shift <= {4'b1111, tx_holding};
          tx_left <= stop_len_select ? 4'ha : 4'h9;
        end
      end else if (tx_busy & tx_bit_tick) begin
        if (tx_left != 4'h0) begin
          o_serial_out_pin <= tx_shift[0];
          tx_shift <= {1'b1, tx_shift[11:1]};
          tx_left <= tx_left - 4'h1;
        end else begin
          tx_busy <= 1'b0;
          o_serial_out_pin <= 1'b1;
          if (~tx_pending & ~tx_write_ok) begin
            tx_done_flag <= 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // Receive input synchroniser and glitch filter
  reg rx_sync_a;
  reg rx_sync_b;
  reg rx_level;
  reg [8:0] filter_count;
  reg [8:0] filter_len;

  always @* begin
    case (rx_glitch_filter)
      2'h1: filter_len = `FILTER_LEN_1;
      2'h2: filter_len = `FILTER_LEN_2;
      default: filter_len = `FILTER_LEN_3;
    endcase
  end

  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      rx_sync_a <= 1'b1;
      rx_sync_b <= 1'b1;
      rx_level <= 1'b1;
      filter_count <= 9'h000;
    end else begin
      rx_sync_a <= i_serial_in_pin;
      rx_sync_b <= rx_sync_a;
      if (rx_glitch_filter == 2'h0) begin
        rx_level <= rx_sync_b;
        filter_count <= 9'h000;
      end else if (rx_sync_b == rx_level) begin
        filter_count <= 9'h000;
      end else if (filter_count == filter_len) begin
        rx_level <= rx_sync_b;
        filter_count <= 9'h000;
      end else begin
        filter_count <= filter_count + 9'h001;
      end
    end
  end

  // ==========================================================
  // Receiver
  reg rx_busy;
  reg [3:0] rx_rt;
  reg [3:0] rx_index;
  reg vote_a;
  reg vote_b;
  reg [7:0] rx_data;
  reg rx_parity_bad;
  wire rx_bit = (vote_a & vote_b) | (vote_a & rx_level) |
    (vote_b & rx_level);
  wire rx_sample = rx_busy & rt_tick & (rx_rt == `RT_SAMPLE_C);
  wire rx_stop = rx_index == (parity_on ? 4'ha : 4'h9);
  wire rx_complete = rx_sample & rx_stop;

  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      rx_busy <= 1'b0;
      rx_rt <= 4'h0;
      rx_index <= 4'h0;
      vote_a <= 1'b1;
      vote_b <= 1'b1;
      rx_data <= 8'h00;
      rx_parity_bad <= 1'b0;
      rx_holding <= `HOLDING_RESET;
      parity_fault_flag <= 1'b0;
      frame_fault_flag <= 1'b0;
      overflow_fault_flag <= 1'b0;
      rx_holding_full <= 1'b0;
      o_rx_irq <= 1'b0;
    end else begin
      o_rx_irq <= 1'b0;
      if (rx_clear) begin
        parity_fault_flag <= 1'b0;
        frame_fault_flag <= 1'b0;
        overflow_fault_flag <= 1'b0;
        rx_holding_full <= 1'b0;
      end
      if (rt_tick & ~rx_busy) begin
        if (rx_enable_bit & ~overflow_fault_flag & ~rx_level) begin
          rx_busy <= 1'b1;
          rx_rt <= 4'h1;
          rx_index <= 4'h0;
          rx_parity_bad <= 1'b0;
        end
      end else if (rt_tick) begin
        rx_rt <= rx_rt + 4'h1;
        if (rx_rt == `RT_SAMPLE_A) begin
          vote_a <= rx_level;
        end
        if (rx_rt == `RT_SAMPLE_B) begin
          vote_b <= rx_level;
        end
      end
      if (rx_sample) begin
        rx_index <= rx_index + 4'h1;
        if (rx_index == 4'h0) begin
          if (rx_bit) begin
            rx_busy <= 1'b0;
          end
        end else if (rx_index <= 4'h8) begin
          rx_data <= {rx_bit, rx_data[7:1]};
        end else if (~rx_stop) begin
          rx_parity_bad <= rx_bit ^ ^rx_data ^ ~parity_sense;
        end
      end
      if (rx_complete) begin
        rx_busy <= 1'b0;
        if (rx_holding_full & ~rx_clear) begin
          overflow_fault_flag <= 1'b1;
        end else begin
          rx_holding <= rx_data;
          rx_holding_full <= 1'b1;
          parity_fault_flag <= rx_parity_bad;
          frame_fault_flag <= ~rx_bit;
          o_rx_irq <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** tb/serial_port_monitor.sv ***
/*
  Checker for the serial port: bus timing, idle line and bit lengths.
  Assumes rate code 0 (208 clocks a bit) and the port's register map.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_port_monitor (
  // Clock and reset
  input wire i_clock,
  input wire i_reset,
  // APB
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [15:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire o_pready,
  input wire [31:0] o_prdata,
  input wire o_pslverr,
  // Serial and events
  input wire i_serial_in_pin,
  input wire o_serial_out_pin,
  input wire o_tx_irq,
  input wire o_rx_irq
);
  localparam int BIT = 208;
  logic tx_quiet;
  logic tx_on;
  logic armed;
  logic [11:0] low_run;
  wire acc = i_psel && i_penable && o_pready;
  wire mapped = i_paddr[15:4] == 12'h3e6 && i_paddr[1:0] == 2'h0;

  // ==========================================================
  // Helper state
  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      tx_quiet <= 1'b1;
      tx_on <= 1'b0;
      armed <= 1'b0;
    end else if (acc && i_pwrite && i_paddr == 16'h3e60) begin
      tx_on <= i_pwdata[7];
      if (i_pwdata[7] && !tx_on) begin
        tx_quiet <= 1'b1;
      end
    end else if (acc && i_pwrite && i_paddr == 16'h3e68) begin
      armed <= 1'b0;
      if (armed && tx_on) begin
        tx_quiet <= 1'b0;
      end
    end else if (acc && i_paddr == 16'h3e60) begin
      armed <= 1'b1;
    end
  end

  always @(posedge i_clock or posedge i_reset) begin
    if (i_reset || o_serial_out_pin) begin
      low_run <= 12'h000;
    end else begin
      low_run <= low_run + 12'h001;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  a_ready_wait: assert property ($rose(i_penable) && i_psel |->
    !o_pready ##1 o_pready) else $error("ready not after one wait");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_slverr_map: assert property (acc |-> o_pslverr == !mapped)
    else $error("error response wrong for address");
  a_rdata_upper: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_out_quiet: assert property (tx_quiet |-> o_serial_out_pin)
    else $error("serial output left idle level");
  a_start_low: assert property (o_tx_irq |-> (!o_serial_out_pin) [*8])
    else $error("transmit event without start bit");
  a_tx_pulse: assert property (o_tx_irq |=> !o_tx_irq)
    else $error("transmit event too long");
  a_rx_pulse: assert property (o_rx_irq |=> !o_rx_irq)
    else $error("receive event too long");
  a_low_whole: assert property ($rose(o_serial_out_pin) |->
    low_run % BIT == 0) else $error("low run not whole bits");

  c_slverr: cover property (acc && o_pslverr);
  c_tx: cover property (o_tx_irq);
  c_rx: cover property (o_rx_irq);
endmodule

bind async_serial_port_two serial_port_monitor serial_port_monitor_inst (
  .i_clock(i_clock), .i_reset(i_reset), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
  .o_pslverr(o_pslverr), .i_serial_in_pin(i_serial_in_pin),
  .o_serial_out_pin(o_serial_out_pin), .o_tx_irq(o_tx_irq),
  .o_rx_irq(o_rx_irq));

`default_nettype wire

// *** tb/serial_partner.sv ***
/*
  Remote serial partner: sends framed characters and decodes those
  the port sends. Assumes a fixed bit length in clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_partner #(
  parameter int BIT = 208
) (
  // Clock and format
  input wire i_clock,
  input wire i_parity_on,
  input wire i_parity_even,
  input wire i_stop_two,
  // Line
  input wire i_line,
  output logic o_line,
  // Decoded character
  output logic o_got,
  output logic [7:0] o_got_data,
  output logic o_got_ok
);
  logic [7:0] d;
  logic ok;

  task automatic bit_out(input logic v);
    o_line <= v;
    repeat (BIT) @(posedge i_clock);
  endtask

  task automatic send(input logic [7:0] c, input logic bad_par,
                      input logic bad_stop);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) begin
      bit_out(c[i]);
    end
    if (i_parity_on) begin
      bit_out(^c ^ !i_parity_even ^ bad_par);
    end
    bit_out(!bad_stop);
    if (i_stop_two) begin
      bit_out(1'b1);
    end
  endtask

  task automatic glitch(input int n);
    o_line <= 1'b0;
    repeat (n) @(posedge i_clock);
    o_line <= 1'b1;
    repeat (12 * BIT) @(posedge i_clock);
  endtask

  // ==========================================================
  // Receiver, sampling mid-bit
  initial begin
    o_line = 1'b1;
    o_got = 1'b0;
    o_got_data = 8'h00;
    o_got_ok = 1'b0;
    forever begin
      @(negedge i_line);
      repeat (BIT / 2) @(posedge i_clock);
      ok = !i_line;
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge i_clock);
        d[i] = i_line;
      end
      if (i_parity_on) begin
        repeat (BIT) @(posedge i_clock);
        ok = ok & (i_line === (^d ^ !i_parity_even));
      end
      repeat (BIT) @(posedge i_clock);
      ok = ok & (i_line === 1'b1);
      if (i_stop_two) begin
        repeat (BIT) @(posedge i_clock);
        ok = ok & (i_line === 1'b1);
      end
      o_got_data <= d;
      o_got_ok <= ok;
      o_got <= 1'b1;
      @(posedge i_clock);
      o_got <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// *** tb/test_async_serial_port_two.sv ***
/*
  Self-checking bench for the second serial port.
  Assumes rate code 0, so one bit lasts 208 clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module test_async_serial_port_two;
  localparam int BIT = 208;
  localparam logic [15:0] CTL = 16'h3e60;
  localparam logic [15:0] HLD = 16'h3e68;
  logic i_clock, i_reset, i_psel, i_penable, i_pwrite, i_serial_in_pin;
  logic [15:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic o_pready, o_pslverr, o_serial_out_pin, o_tx_irq, o_rx_irq;
  logic par_on, par_even, stop_two, got, got_ok;
  logic [7:0] got_data, d;
  logic [33:0] nt;
  logic [33:0] note_q[$];
  logic [7:0] tx_q[$];
  logic [7:0] cfgs [4] = '{8'hc0, 8'he8, 8'hd8, 8'hf8};
  int miscompares = 0;
  int compares = 0;
  int tx_irqs = 0;
  int rx_irqs = 0;

  async_serial_port_two async_serial_port_two_inst (
    .i_clock(i_clock), .i_reset(i_reset), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .i_serial_in_pin(i_serial_in_pin),
    .o_serial_out_pin(o_serial_out_pin), .o_tx_irq(o_tx_irq),
    .o_rx_irq(o_rx_irq));

  serial_partner #(.BIT(BIT)) serial_partner_inst (
    .i_clock(i_clock), .i_parity_on(par_on), .i_parity_even(par_even),
    .i_stop_two(stop_two), .i_line(o_serial_out_pin),
    .o_line(i_serial_in_pin), .o_got(got), .o_got_data(got_data),
    .o_got_ok(got_ok));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [31:0] v, input logic [33:0] note);
    note_q.push_back(note);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= v;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (o_pready !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, {2'b10, exp});
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h0, v}, 34'h0);
  endtask

  task automatic rx_expect(input logic [7:0] st, input logic [7:0] v);
    rd(CTL, {24'h0, st});
    rd(HLD, {24'h0, v});
    rd(CTL, 32'h0c);
  endtask

  task automatic wait_tx(input int target);
    while (tx_irqs < target || tx_q.size() != 0) begin
      @(posedge i_clock);
    end
  endtask

  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Result watcher
  always @(posedge i_clock) begin
    if (i_psel && i_penable && o_pready === 1'b1) begin
      nt = note_q.pop_front();
      check("slverr", {31'h0, o_pslverr}, {31'h0, nt[32]});
      if (nt[33]) check("prdata", o_prdata, nt[31:0]);
    end
    if (got === 1'b1) begin
      check("tx data", {24'h0, got_data}, {24'h0, tx_q.pop_front()});
      check("tx frame", {31'h0, got_ok}, 32'h1);
    end
    if (o_tx_irq === 1'b1) tx_irqs++;
    if (o_rx_irq === 1'b1) rx_irqs++;
  end

  initial begin
    repeat (90000) @(posedge i_clock);
    miscompares++;
    complete_run;
  end

  // ==========================================================
  // Main sequence
  initial begin
    {i_psel, i_penable, i_pwrite, par_on, par_even, stop_two} = 6'h0;
    i_paddr = 16'h0;
    i_pwdata = 32'h0;
    i_reset = 1'b1;
    repeat (16) @(posedge i_clock);
    i_reset <= 1'b0;
    @(posedge i_clock);
    void'($urandom(32'h1563));
    rd(CTL, 32'h0c);
    rd(HLD, 32'h0);
    rd(16'h3e6c, 32'h1);
    wr(16'h3e64, 8'h02);
    rd(16'h3e64, 32'h2);
    wr(16'h3e64, 8'h00);
    apb(1'b1, 16'h3e70, 32'h0, {2'b01, 32'h0});
    wr(CTL, 8'h40);
    wr(HLD, 8'ha5);
    wr(CTL, 8'hc0);
    wr(HLD, 8'h5a);
    repeat (3 * BIT) @(posedge i_clock);
    rd(CTL, 32'h0c);
    for (int k = 0; k < 4; k++) begin
      wr(CTL, cfgs[k]);
      par_on <= cfgs[k][3];
      par_even <= cfgs[k][4];
      stop_two <= cfgs[k][5];
      rd(CTL, 32'h0c);
      d = $urandom;
      tx_q.push_back(d);
      wr(HLD, d);
      wait_tx(2 * k + 1);
      rd(CTL, 32'h04);
      d = $urandom;
      tx_q.push_back(d);
      wr(HLD, d);
      wait_tx(2 * k + 2);
      repeat (BIT) @(posedge i_clock);
      rd(CTL, 32'h0c);
      d = $urandom;
      serial_partner_inst.send(d, 1'b0, 1'b0);
      rx_expect(8'h1c, d);
    end
    d = $urandom;
    serial_partner_inst.send(d, 1'b1, 1'b0);
    rx_expect(8'h9c, d);
    serial_partner_inst.send(d, 1'b0, 1'b1);
    rx_expect(8'h5c, d);
    serial_partner_inst.send(8'h3c, 1'b0, 1'b0);
    serial_partner_inst.send(8'hc3, 1'b0, 1'b0);
    serial_partner_inst.send(8'h99, 1'b0, 1'b0);
    rx_expect(8'h3c, 8'h3c);
    wr(16'h3e64, 8'h02);
    serial_partner_inst.glitch(150);
    rd(CTL, 32'h0c);
    serial_partner_inst.send(8'h81, 1'b0, 1'b0);
    rx_expect(8'h1c, 8'h81);
    check("tx events", tx_irqs, 32'd8);
    check("rx events", rx_irqs, 32'd8);
    complete_run;
  end
endmodule

`default_nettype wire
